/* src/dhb_pkg.sv */
// Purpose: Shared constants and carriers for the display host bus port
// Assumes: 10 MHz system clock
// Notes:   Strap codes are read as {strap0, strap1, strap2}
package dhb_pkg;

   localparam logic [2:0] STRAP_STROBED = 3'h3;
   localparam logic [2:0] STRAP_I2C     = 3'h2;
   localparam logic [2:0] STRAP_ENABLE  = 3'h1;
   localparam logic [2:0] STRAP_SERIAL  = 3'h0;

   localparam logic [7:0] DISPLAY_ON_CMD  = 8'hAF;
   localparam logic [7:0] DISPLAY_OFF_CMD = 8'hAE;

   localparam logic [6:0] I2C_ADDR_UPPER = 7'h3C;

   localparam int CLK_HZ          = 10_000_000;
   localparam int SEG_ON_DELAY_MS = 100;
   localparam int SEG_ON_CYCLES   = SEG_ON_DELAY_MS * (CLK_HZ / 1000);

   typedef enum logic [3:0] {
      MODE_STROBED = 4'h1,
      MODE_ENABLE  = 4'h2,
      MODE_SERIAL  = 4'h4,
      MODE_I2C     = 4'h8
   } dhb_mode_e;

   typedef struct packed {
      logic       is_data;
      logic [7:0] value;
   } dhb_byte_s;

endpackage

/* src/dhb_port.sv */
// Purpose: Host-facing port of a monochrome display driver: four bus modes
// Assumes: All host pins are asynchronous to ref_clk_i; serial clock is link_clk_i
// Notes:   Received bytes appear as one-cycle strobes on the system clock
`timescale 1ns/1ns
module dhb_port
   import dhb_pkg::*;
#(
   parameter int SEG_DELAY = SEG_ON_CYCLES
) (
   // System
   input  wire logic       ref_clk_i,
   input  wire logic       rst_i,
   // Serial link clock, taken from data bit 0
   input  wire logic       link_clk_i,
   // Host pins
   input  wire logic       reset_pad_n_i,
   input  wire logic       chip_select_n_i,
   input  wire logic       data_command_select_i,
   input  wire logic       write_strobe_rw_i,
   input  wire logic       read_strobe_enable_i,
   input  wire logic       interface_strap_0_i,
   input  wire logic       interface_strap_1_i,
   input  wire logic       interface_strap_2_i,
   input  wire logic [7:0] host_data_bus_i,
   output logic      [7:0] host_data_bus_o,
   output logic      [7:0] host_data_bus_oe_o,
   // Core side
   input  wire logic [7:0] read_data_i,
   output dhb_byte_s       rx_byte_o,
   output logic            rx_valid_o,
   output logic            display_on_o,
   output logic            segment_common_outputs_o
);

   // Pin synchronisers: first stage feeds only the second
   logic [15:0] pin_s1_q, pin_s2_q;
   always_ff @(posedge ref_clk_i) begin
      pin_s1_q <= {reset_pad_n_i, chip_select_n_i, data_command_select_i,
                   write_strobe_rw_i, read_strobe_enable_i, interface_strap_0_i,
                   interface_strap_1_i, interface_strap_2_i, host_data_bus_i};
      pin_s2_q <= pin_s1_q;
   end

   logic       rst_pin_n, cs_n, dc, wr, rd;
   logic [2:0] strap;
   logic [7:0] dbus;
   assign {rst_pin_n, cs_n, dc, wr, rd, strap, dbus} = pin_s2_q;

   // Level-sensitive reset combines the system reset and the pad
   logic hold_rst;
   assign hold_rst = rst_i || !rst_pin_n;

   function automatic dhb_mode_e decode_mode(input logic [2:0] s);
      case (s)
         STRAP_STROBED: decode_mode = MODE_STROBED;
         STRAP_I2C:     decode_mode = MODE_I2C;
         STRAP_ENABLE:  decode_mode = MODE_ENABLE;
         default:       decode_mode = MODE_SERIAL;
      endcase
   endfunction

   // Straps are caught while reset is held and kept afterwards
   dhb_mode_e mode_q;
   always_ff @(posedge ref_clk_i) begin
      if (hold_rst) begin
         mode_q <= decode_mode(strap);
      end
   end

   // Previous strobe levels; reset values match the enable-mode idle pins, so no false edge
   logic wr_d1_q, rd_d1_q;
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         wr_d1_q <= 1'b1;
         rd_d1_q <= 1'b0;
      end else begin
         wr_d1_q <= wr;
         rd_d1_q <= rd;
      end
   end

   // Parallel capture
   logic      par_hit;
   dhb_byte_s par_byte;
   always_comb begin
      par_hit  = 1'b0;
      par_byte = '{is_data: dc, value: dbus};
      if (!hold_rst && !cs_n) begin
         case (mode_q)
            MODE_STROBED: par_hit = wr && !wr_d1_q;
            MODE_ENABLE:  par_hit = !rd && rd_d1_q && !wr;
            default:      par_hit = 1'b0;
         endcase
      end
   end

   // Link domain: serial and I2C receivers on the link clock
   // The link clock only runs inside frames, so a synchronised reset can never
   // reach these flops before the first bit; the reset stages, shifter, bit count and toggle start from known power-up values
   logic       lk_rst_s1_q = 1'b1;
   logic       lk_rst_s2_q = 1'b1;
   logic       lk_cs_s1_q, lk_cs_s2_q;
   logic       lk_dc_s1_q, lk_dc_s2_q;
   logic [7:0] lk_sh_q     = 8'h00;
   logic [2:0] lk_cnt_q    = 3'h0;
   logic [7:0] lk_word_q;
   logic       lk_word_dc_q;
   logic       lk_tog_q    = 1'b0;
   logic       lk_i2c_q;
   always_ff @(posedge link_clk_i) begin
      lk_rst_s1_q <= hold_rst || !(mode_q[2] || mode_q[3]);
      lk_rst_s2_q <= lk_rst_s1_q;
      lk_cs_s1_q  <= chip_select_n_i;
      lk_cs_s2_q  <= lk_cs_s1_q;
      lk_dc_s1_q  <= data_command_select_i;
      lk_dc_s2_q  <= lk_dc_s1_q;
   end

   // Serial clock on bit 0, data on bit 1; MSB first
   always_ff @(posedge link_clk_i) begin
      // Chip select alone frames the bit count: it clears only on a link clock edge seen with chip select high
      if (chip_select_n_i) begin
         lk_cnt_q <= 3'h0;
         lk_sh_q  <= 8'h00;
      end else begin
         lk_sh_q  <= {lk_sh_q[6:0], host_data_bus_i[1]};
         lk_cnt_q <= lk_cnt_q + 3'h1;
      end
   end

   always_ff @(posedge link_clk_i) begin
      if (lk_rst_s2_q) begin
         lk_tog_q     <= 1'b0;
         lk_word_q    <= 8'h00;
         lk_word_dc_q <= 1'b0;
      end else if (!chip_select_n_i && lk_cnt_q == 3'h7) begin
         lk_word_q    <= {lk_sh_q[6:0], host_data_bus_i[1]};
         lk_word_dc_q <= data_command_select_i;
         lk_tog_q     <= !lk_tog_q;
      end
   end

   // I2C: slave address low bit comes from data/command select
   // Address match only; the I2C payload is not handed to the core
   logic [6:0] i2c_addr;
   assign i2c_addr = {I2C_ADDR_UPPER[6:1], lk_dc_s2_q};
   always_ff @(posedge link_clk_i) begin
      if (lk_rst_s2_q) begin
         lk_i2c_q <= 1'b0;
      end else begin
         lk_i2c_q <= (mode_q == MODE_I2C) && (lk_sh_q[7:1] == i2c_addr);
      end
   end

   // Toggle crossing back to the system clock
   // Only the toggle crosses; the word is already stable when the toggle is seen
   logic tog_s1_q, tog_s2_q, tog_s3_q;
   logic lk_word_dc_sys;
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         tog_s1_q <= 1'b0;
         tog_s2_q <= 1'b0;
         tog_s3_q <= 1'b0;
      end else begin
         tog_s1_q <= lk_tog_q;
         tog_s2_q <= tog_s1_q;
         tog_s3_q <= tog_s2_q;
      end
   end
   assign lk_word_dc_sys = lk_word_dc_q;

   logic ser_hit;
   assign ser_hit = (tog_s2_q != tog_s3_q) && !hold_rst && mode_q == MODE_SERIAL;

   // Byte output to core
   always_ff @(posedge ref_clk_i) begin
      if (hold_rst) begin
         rx_valid_o <= 1'b0;
         rx_byte_o  <= '0;
      end else begin
         rx_valid_o <= par_hit || ser_hit;
         if (par_hit) begin
            rx_byte_o <= par_byte;
         end else if (ser_hit) begin
            rx_byte_o <= '{is_data: lk_word_dc_sys, value: lk_word_q};
         end
      end
   end

   // Read path drives the bus only in parallel modes
   // Drive follows the strobe three cycles late; the host must allow for that lag
   always_ff @(posedge ref_clk_i) begin
      if (hold_rst) begin
         host_data_bus_o    <= 8'h00;
         host_data_bus_oe_o <= 8'h00;
      end else begin
         host_data_bus_o <= read_data_i;
         if (!cs_n && mode_q == MODE_STROBED && !rd) begin
            host_data_bus_oe_o <= 8'hFF;
         end else if (!cs_n && mode_q == MODE_ENABLE && rd && wr) begin
            host_data_bus_oe_o <= 8'hFF;
         end else begin
            host_data_bus_oe_o <= 8'h00;
         end
      end
   end

   // Display on/off and the delayed panel output enable
   logic [31:0] seg_cnt_q;
   always_ff @(posedge ref_clk_i) begin
      if (hold_rst) begin
         display_on_o <= 1'b0;
      end else if (rx_valid_o && !rx_byte_o.is_data) begin
         if (rx_byte_o.value == DISPLAY_ON_CMD) begin
            display_on_o <= 1'b1;
         end else if (rx_byte_o.value == DISPLAY_OFF_CMD) begin
            display_on_o <= 1'b0;
         end
      end
   end

   // Counter stops at its end value, so the panel stays on until display off
   always_ff @(posedge ref_clk_i) begin
      if (hold_rst || !display_on_o) begin
         seg_cnt_q                <= 32'h0;
         segment_common_outputs_o <= 1'b0;
      end else if (seg_cnt_q == 32'(SEG_DELAY - 1)) begin
         segment_common_outputs_o <= 1'b1;
      end else begin
         seg_cnt_q <= seg_cnt_q + 32'h1;
      end
   end

   // Panel power ordering
   a_seg_delay: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      $rose(segment_common_outputs_o) |-> seg_cnt_q == 32'(SEG_DELAY - 1))
      else $error("panel outputs rose before the delay");

   a_seg_off: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      !display_on_o |=> !segment_common_outputs_o)
      else $error("panel outputs on while display is off");

   a_display_on: assert property (@(posedge ref_clk_i) disable iff (hold_rst)
      (rx_valid_o && !rx_byte_o.is_data && rx_byte_o.value == DISPLAY_ON_CMD)
      |=> display_on_o)
      else $error("display on command ignored");

   a_display_off: assert property (@(posedge ref_clk_i) disable iff (hold_rst)
      (rx_valid_o && !rx_byte_o.is_data && rx_byte_o.value == DISPLAY_OFF_CMD)
      |=> !display_on_o)
      else $error("display off command ignored");

   a_cmd_ignore: assert property (@(posedge ref_clk_i) disable iff (hold_rst)
      (rx_valid_o && rx_byte_o.is_data) |=> $stable(display_on_o))
      else $error("display data acted on as a command");

   // Selection and reset
   a_rx_no_cs: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      par_hit |-> !cs_n)
      else $error("byte taken with chip select high");

   a_idle_quiet: assert property (@(posedge ref_clk_i) disable iff (hold_rst)
      (cs_n && !ser_hit) |=> !rx_valid_o)
      else $error("byte delivered while deselected");

   a_reset_hold: assert property (@(posedge ref_clk_i)
      !rst_pin_n |=> !rx_valid_o && !display_on_o)
      else $error("settings moved under reset");

   a_rx_reset: assert property (@(posedge ref_clk_i)
      hold_rst |=> !rx_valid_o)
      else $error("byte delivered under reset");

   a_mode_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      !hold_rst |=> $stable(mode_q))
      else $error("mode changed outside reset");

   // Parallel capture and bus drive
   a_strobe_rise: assert property (@(posedge ref_clk_i) disable iff (hold_rst)
      (mode_q == MODE_STROBED && par_hit) |-> wr && !wr_d1_q)
      else $error("write taken off a rising edge");

   a_read_drive: assert property (@(posedge ref_clk_i) disable iff (hold_rst)
      (mode_q == MODE_STROBED && rd) |=> host_data_bus_oe_o == 8'h00)
      else $error("bus driven without read strobe");

   a_strobe_read: assert property (@(posedge ref_clk_i) disable iff (hold_rst)
      (mode_q == MODE_STROBED && !cs_n && !rd) |=> host_data_bus_oe_o == 8'hFF)
      else $error("bus not driven under read strobe");

   a_enable_rw: assert property (@(posedge ref_clk_i) disable iff (hold_rst)
      (mode_q == MODE_ENABLE && par_hit) |-> !wr)
      else $error("write taken with read select");

   a_enable_read: assert property (@(posedge ref_clk_i) disable iff (hold_rst)
      (mode_q == MODE_ENABLE && !cs_n && rd && wr) |=> host_data_bus_oe_o == 8'hFF)
      else $error("bus not driven in enabled read");

   a_enable_idle: assert property (@(posedge ref_clk_i) disable iff (hold_rst)
      (mode_q == MODE_ENABLE && !(rd && wr)) |=> host_data_bus_oe_o == 8'h00)
      else $error("bus driven outside enabled read");

   a_oe_whole: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      host_data_bus_oe_o == 8'h00 || host_data_bus_oe_o == 8'hFF)
      else $error("bus drive split across bits");

   a_par_dc: assert property (@(posedge ref_clk_i) disable iff (hold_rst)
      par_hit |=> rx_byte_o.is_data == $past(dc))
      else $error("data/command flag lost");

   a_par_value: assert property (@(posedge ref_clk_i) disable iff (hold_rst)
      par_hit |=> rx_valid_o && rx_byte_o.value == $past(dbus))
      else $error("parallel byte value lost");

   // Serial modes
   a_serial_float: assert property (@(posedge ref_clk_i) disable iff (hold_rst)
      (mode_q == MODE_SERIAL) |=> host_data_bus_oe_o == 8'h00)
      else $error("bus driven in serial mode");

   a_serial_byte: assert property (@(posedge ref_clk_i) disable iff (hold_rst)
      ser_hit |=> rx_valid_o && rx_byte_o.value == $past(lk_word_q))
      else $error("serial byte not delivered");

   a_i2c_float: assert property (@(posedge ref_clk_i) disable iff (hold_rst)
      (mode_q == MODE_I2C) |=> host_data_bus_oe_o == 8'h00)
      else $error("bus driven in I2C mode");

endmodule

/* verification/dhb_host_model.sv */
// Purpose: Host processor model driving the display port pins
// Assumes: Parallel pins change just after a ref clock edge; serial clock 32 ns
// Notes:   A released bus shows the inverted last value, so stale data never passes
`timescale 1ns/1ns
module dhb_host_model (
   // Clock
   input  wire logic  clk_i,
   // Host pins
   output logic       lclk_o,
   output logic       cs_n_o,
   output logic       dc_o,
   output logic       wr_o,
   output logic       rd_o,
   output logic [7:0] d_o
);
   initial begin
      lclk_o = 1'b0;
      cs_n_o = 1'b1;
      dc_o = 1'b0;
      wr_o = 1'b1;
      rd_o = 1'b1;
      d_o = 8'h00;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic idle(input logic strobed);
      wr_o = 1'b1;
      rd_o = strobed;
   endtask
   task automatic par_wr(input logic strobed, sel, dc, input logic [7:0] v);
      cs_n_o = ~sel;
      dc_o = dc;
      d_o = v;
      wr_o = 1'b0;
      if (!strobed) rd_o = 1'b1;
      tick(3);
      if (strobed) wr_o = 1'b1;
      else rd_o = 1'b0;
      tick(3);
      cs_n_o = 1'b1;
      wr_o = 1'b1;
      d_o = ~v;
      tick(3);
   endtask
   task automatic rd_set(input logic on);
      cs_n_o = ~on;
      rd_o = ~on;
      d_o = ~d_o;
   endtask
   // Link clock only runs inside the frame
   task automatic ser_wr(input logic dc, input logic [7:0] v);
      cs_n_o = 1'b0;
      dc_o = dc;
      for (int i = 7; i >= 0; i--) begin
         d_o[1] = v[i];
         #16 lclk_o = 1'b1;
         d_o[0] = 1'b1;
         #16 lclk_o = 1'b0;
         d_o[0] = 1'b0;
      end
      d_o[1] = ~v[0];
      tick(8);
      cs_n_o = 1'b1;
   endtask
endmodule

/* verification/test_display_host_bus_port.sv */
// Purpose: Self-checking bench for the display host bus port
// Assumes: Straps change only while reset is held
// Notes:   Segment delay is shortened to keep the run brief
`timescale 1ns/1ns
module test_display_host_bus_port;
   import dhb_pkg::*;
   localparam int SEG_SIM = 20;
   logic       ref_clk_i = 1'b0;
   logic       rst_i = 1'b1;
   logic       pad_n = 1'b1;
   logic [2:0] strap = STRAP_STROBED;
   logic       lclk, cs_n, dc, wr, rd, rx_v, d_on, seg_on;
   logic [7:0] d, bus, bus_o, oe;
   dhb_byte_s  rx, got;
   int         num_errors = 0, comparisons = 0, nrx = 0, on_cnt = 0, cyc = 0;
   always #50 ref_clk_i = ~ref_clk_i;
   assign bus = (oe & bus_o) | (~oe & d);
   dhb_host_model h (.clk_i(ref_clk_i), .lclk_o(lclk), .cs_n_o(cs_n), .dc_o(dc),
      .wr_o(wr), .rd_o(rd), .d_o(d));
   dhb_port #(.SEG_DELAY(SEG_SIM)) dhb_port_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .link_clk_i(lclk), .reset_pad_n_i(pad_n), .chip_select_n_i(cs_n),
      .data_command_select_i(dc), .write_strobe_rw_i(wr), .read_strobe_enable_i(rd),
      .interface_strap_0_i(strap[2]), .interface_strap_1_i(strap[1]),
      .interface_strap_2_i(strap[0]), .host_data_bus_i(bus), .host_data_bus_o(bus_o),
      .host_data_bus_oe_o(oe), .read_data_i(rx.value), .rx_byte_o(rx), .rx_valid_o(rx_v),
      .display_on_o(d_on), .segment_common_outputs_o(seg_on));
   always @(posedge ref_clk_i) begin
      cyc <= cyc + 1;
      if (rx_v === 1'b1) begin
         got <= rx;
         nrx <= nrx + 1;
      end
      if (d_on === 1'b1 && seg_on !== 1'b1) on_cnt <= on_cnt + 1;
   end
   // Whole run needs under 1000 cycles
   always @(posedge ref_clk_i) if (cyc == 6000) begin
      num_errors++;
      complete_run();
   end
   task automatic check(input logic [8:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic mode(input logic [2:0] s);
      rst_i = 1'b1;
      strap = s;
      h.idle(s == STRAP_STROBED);
      h.tick(12);
      on_cnt = 0;
      rst_i = 1'b0;
      h.tick(4);
   endtask
   task automatic t_strobed();
      int n0;
      mode(STRAP_STROBED);
      h.par_wr(1'b1, 1'b1, 1'b0, DISPLAY_ON_CMD);
      check(got, {1'b0, DISPLAY_ON_CMD});
      check(d_on, 1'b1);
      h.tick(SEG_SIM + 5);
      check(seg_on, 1'b1);
      check(on_cnt >= SEG_SIM && on_cnt <= SEG_SIM + 1, 1'b1);
      n0 = nrx;
      h.par_wr(1'b1, 1'b0, 1'b1, 8'h3C);
      check(9'(nrx - n0), 9'h000);
      h.rd_set(1'b1);
      h.tick(5);
      check(oe, 8'hFF);
      check(bus, DISPLAY_ON_CMD);
      h.rd_set(1'b0);
      h.tick(5);
      check(oe, 8'h00);
      h.par_wr(1'b1, 1'b1, 1'b0, DISPLAY_OFF_CMD);
      check(d_on, 1'b0);
      h.par_wr(1'b1, 1'b1, 1'b1, DISPLAY_ON_CMD);
      check(got, {1'b1, DISPLAY_ON_CMD});
      check(d_on, 1'b0);
      $display("test strobed done");
   endtask
   task automatic t_reset();
      int n0;
      h.par_wr(1'b1, 1'b1, 1'b0, DISPLAY_ON_CMD);
      pad_n = 1'b0;
      h.tick(30);
      check(d_on, 1'b0);
      n0 = nrx;
      h.par_wr(1'b1, 1'b1, 1'b1, 8'h77);
      check(9'(nrx - n0), 9'h000);
      check(d_on, 1'b0);
      pad_n = 1'b1;
      h.tick(30);
      h.par_wr(1'b1, 1'b1, 1'b0, DISPLAY_ON_CMD);
      check(d_on, 1'b1);
      $display("test reset done");
   endtask
   task automatic t_other();
      int n0;
      mode(STRAP_ENABLE);
      h.par_wr(1'b0, 1'b1, 1'b1, 8'hC3);
      check(got, {1'b1, 8'hC3});
      mode(STRAP_SERIAL);
      h.ser_wr(1'b0, DISPLAY_ON_CMD);
      check(got, {1'b0, DISPLAY_ON_CMD});
      check(d_on, 1'b1);
      check(oe, 8'h00);
      mode(STRAP_I2C);
      n0 = nrx;
      h.par_wr(1'b1, 1'b1, 1'b1, 8'h3C);
      check(9'(nrx - n0), 9'h000);
      check(oe, 8'h00);
      $display("test modes done");
   endtask
   initial begin
      h.tick(12);
      rst_i = 1'b0;
      t_strobed();
      t_reset();
      t_other();
      complete_run();
   end
endmodule
